// ==== hw/amo_pkg.sv ====
package amo_pkg;

  localparam int ADDR_W = 12;
  localparam int IDX_W  = ADDR_W - 2;
  localparam int DATA_W = 32;
  localparam int LANES  = 8;
  localparam int TRIMS  = 3;
  localparam int TRIM_W = 12;
  localparam int REG_W  = 16;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_ALARM_SUMMARY = 10'h2c0;
  localparam logic [IDX_W-1:0] IDX_ALARM_STATUS  = 10'h2c1;
  localparam logic [IDX_W-1:0] IDX_ALARM_MASK    = 10'h2c2;
  localparam logic [IDX_W-1:0] IDX_LANE_FIFO     = 10'h2c4;
  localparam logic [IDX_W-1:0] IDX_CORE0_TRIM    = 10'h330;
  localparam logic [IDX_W-1:0] IDX_CORE1_TRIM    = 10'h332;
  localparam logic [IDX_W-1:0] IDX_CORE2A_TRIM   = 10'h334;
  localparam logic [IDX_W-1:0] IDX_CAL_CTRL      = 10'h340;
  localparam logic [IDX_W-1:0] IDX_CAL_STATUS    = 10'h341;

  // alarm status and mask field positions
  localparam int BIT_FIFO     = 5;
  localparam int BIT_PLL      = 4;
  localparam int BIT_LINK     = 3;
  localparam int BIT_REALIGN  = 2;
  localparam int BIT_RSVD_ONE = 1;
  localparam int BIT_DIVIDER  = 0;

  // calibration control and status field positions
  localparam int BIT_OFFSET_CAL_ENABLE   = 0;
  localparam int BIT_BACKGROUND_CAL_ENABLE   = 1;
  localparam int BIT_BACKGROUND_OFFSET_CAL_ENABLE = 2;
  localparam int BIT_FOREGROUND_CAL_DONE  = 0;
  localparam int BIT_CAL_BUSY = 1;
  localparam int BIT_CLASH    = 2;
  localparam int BIT_LOADED   = 3;

  localparam logic [7:0]        MASK_RESET     = 8'h3f;
  localparam logic [5:0]        STATUS_RESET   = 6'h3f;
  localparam logic [5:0]        SUMMARY_BITS   = 6'h3d;
  localparam logic [7:0]        LANE_RESET     = 8'hff;
  localparam logic [REG_W-1:0]  TRIM_RESET     = 16'h0000;
  localparam logic [2:0]        CAL_CTRL_RESET = 3'h0;
  localparam logic [3:0]        RSVD_TRIM      = 4'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef logic [TRIMS-1:0][TRIM_W-1:0] amo_trim_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } amo_axi_req_s;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } amo_axi_rsp_s;

  typedef struct packed {
    logic [LANES-1:0] lane_fifo_fault;
    logic [LANES-1:0] lane_active;
    logic             pll_unlock;
    logic             link_down;
    logic             realign;
    logic             divider_mismatch;
  } amo_fault_s;

  typedef struct packed {
    logic              offset_cal_busy;
    logic              foreground_cal_done;
    logic [TRIMS-1:0]  trim_we;
    logic [TRIM_W-1:0] trim_value;
  } amo_cal_s;

  typedef enum logic [2:0] {
    LD_WAIT = 3'b001,
    LD_LOAD = 3'b010,
    LD_DONE = 3'b100
  } amo_load_e;

endpackage

// ==== hw/amo_fuse_loader.sv ====
`timescale 1ns/1ns
module amo_fuse_loader (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic fuse_ready,
  output logic      load,
  output logic      loaded
);
  import amo_pkg::*;

  typedef struct packed {
    amo_load_e st;
  } amo_loader_s;

  amo_loader_s cur;
  amo_loader_s next_cur;

  // one load per reset: later fuse_ready edges are ignored
  always_comb begin
    next_cur = cur;
    unique case (cur.st)
      LD_WAIT: begin
        if (fuse_ready) begin
          next_cur.st = LD_LOAD;
        end
      end
      LD_LOAD: begin
        next_cur.st = LD_DONE;
      end
      LD_DONE: begin
        next_cur.st = LD_DONE;
      end
      default: begin
        next_cur.st = LD_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cur.st <= LD_WAIT;
    end else begin
      cur <= next_cur;
    end
  end

  assign load   = (cur.st == LD_LOAD);
  assign loaded = (cur.st == LD_DONE);

endmodule

// ==== hw/amo_regs.sv ====
`timescale 1ns/1ns
module amo_regs (
  input  wire logic                  CLK,
  input  wire logic                  RESET_N,
  input  wire amo_pkg::amo_axi_req_s AXI_REQ,
  output amo_pkg::amo_axi_rsp_s      AXI_RSP,
  input  wire amo_pkg::amo_fault_s   FAULT_IN,
  input  wire amo_pkg::amo_cal_s     CAL_IN,
  input  wire logic                  FUSE_READY,
  input  wire amo_pkg::amo_trim_t    FUSE_TRIM,
  output amo_pkg::amo_trim_t         CORE_TRIM,
  output logic                       ALARM_SUMMARY,
  output logic                       OFFSET_CAL_EN,
  output logic                       BG_CAL_EN,
  output logic                       BG_OFFSET_CAL_EN,
  output logic                       SPARE_FG_OFFSET_CAL_EN,
  output logic                       TRIM_ACCESS_OK
);
  import amo_pkg::*;

  typedef struct packed {
    logic                          aw_held;
    logic [IDX_W-1:0]              aw_idx;
    logic                          w_held;
    logic [DATA_W-1:0]             wdata;
    logic [3:0]                    wstrb;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          rvalid;
    logic [DATA_W-1:0]             rdata;
    logic [1:0]                    rresp;
    logic [7:0]                    mask;
    logic [5:0]                    status;
    logic [LANES-1:0]              lane;
    logic [TRIMS-1:0][REG_W-1:0]   trim;
    logic [2:0]                    cal_ctrl;
    logic                          clash;
    logic [1:0]                    fuse_sync;
  } amo_state_s;

  amo_state_s cur;
  amo_state_s next_cur;

  logic                fuse_load;
  logic                fuse_loaded;
  logic [IDX_W-1:0]    ar_idx;
  logic                aw_take;
  logic                w_take;
  logic                ar_take;
  logic                wr_commit;
  logic [5:0]          status_set;
  logic                fifo_event;
  logic                summary;
  logic                restricted;
  logic                wr_is_trim;
  logic                rd_is_trim;
  logic [DATA_W-1:0]   rd_value;
  logic                rd_hit;
  logic                wr_hit;
  logic [REG_W-1:0]    wr_bytemask;
  logic                offset_cal_enable;
  logic                background_cal_enable;
  logic                background_offset_cal_enable;
  logic [TRIMS-1:0]    wr_trim_sel;
  logic [TRIMS-1:0]    rd_trim_sel;

  localparam logic [TRIMS-1:0][IDX_W-1:0] TRIM_IDX = {IDX_CORE2A_TRIM, IDX_CORE1_TRIM, IDX_CORE0_TRIM};

  // trims reload from fuses only after a full reset
  amo_fuse_loader u_fuse_loader (
    .clk        (CLK),
    .reset_n    (RESET_N),
    .fuse_ready (cur.fuse_sync[1]),
    .load       (fuse_load),
    .loaded     (fuse_loaded)
  );

  assign offset_cal_enable   = cur.cal_ctrl[BIT_OFFSET_CAL_ENABLE];
  assign background_cal_enable   = cur.cal_ctrl[BIT_BACKGROUND_CAL_ENABLE];
  assign background_offset_cal_enable = cur.cal_ctrl[BIT_BACKGROUND_OFFSET_CAL_ENABLE];

  // bus handshakes; a pending response blocks new writes, a pending read new reads
  assign aw_take   = AXI_REQ.awvalid && !cur.aw_held && !cur.bvalid;
  assign w_take    = AXI_REQ.wvalid && !cur.w_held && !cur.bvalid;
  assign ar_take   = AXI_REQ.arvalid && !cur.rvalid;
  assign wr_commit = cur.aw_held && cur.w_held && !cur.bvalid;
  assign ar_idx    = AXI_REQ.araddr[ADDR_W-1:2];

  assign wr_bytemask = {{8{cur.wstrb[1]}}, {8{cur.wstrb[0]}}};

  // fault sources, level sensitive: a held fault keeps re-setting its bit
  assign fifo_event = |(FAULT_IN.lane_fifo_fault & FAULT_IN.lane_active);

  always_comb begin
    status_set               = 6'h00;
    status_set[BIT_FIFO]     = fifo_event;
    status_set[BIT_PLL]      = FAULT_IN.pll_unlock;
    status_set[BIT_LINK]     = FAULT_IN.link_down;
    status_set[BIT_REALIGN]  = FAULT_IN.realign;
    status_set[BIT_DIVIDER]  = FAULT_IN.divider_mismatch;
  end

  // reserved bit 1 never feeds the summary even though it resets high
  assign summary = |(cur.status & ~cur.mask[5:0] & SUMMARY_BITS);

  // windows in which the calibration engine may be rewriting the trims
  always_comb begin
    restricted = CAL_IN.offset_cal_busy;
    if (offset_cal_enable && (!background_cal_enable || !background_offset_cal_enable) && !CAL_IN.foreground_cal_done) begin
      restricted = 1'b1;
    end
    if (background_cal_enable && background_offset_cal_enable) begin
      restricted = 1'b1;
    end
  end

  // a write and a read decoder per trim; the write one feeds the write path, both feed the misuse check
  generate
    for (genvar g = 0; g < TRIMS; g++) begin : g_trim_sel
      assign wr_trim_sel[g] = (cur.aw_idx == TRIM_IDX[g]);
      assign rd_trim_sel[g] = (ar_idx == TRIM_IDX[g]);
    end
  endgenerate

  assign wr_is_trim = |wr_trim_sel;
  assign rd_is_trim = |rd_trim_sel;

  // read mux; unused upper bits read zero, reserved bits read back as stored
  always_comb begin
    rd_value = '0;
    rd_hit   = 1'b1;
    unique case (ar_idx)
      IDX_ALARM_SUMMARY: begin
        rd_value[0] = summary;
      end
      IDX_ALARM_STATUS: begin
        rd_value[5:0] = cur.status;
      end
      IDX_ALARM_MASK: begin
        rd_value[7:0] = cur.mask;
      end
      IDX_LANE_FIFO: begin
        rd_value[LANES-1:0] = cur.lane;
      end
      IDX_CORE0_TRIM: begin
        rd_value[REG_W-1:0] = cur.trim[0];
      end
      IDX_CORE1_TRIM: begin
        rd_value[REG_W-1:0] = cur.trim[1];
      end
      IDX_CORE2A_TRIM: begin
        rd_value[REG_W-1:0] = cur.trim[2];
      end
      IDX_CAL_CTRL: begin
        rd_value[2:0] = cur.cal_ctrl;
      end
      IDX_CAL_STATUS: begin
        rd_value[BIT_FOREGROUND_CAL_DONE]  = CAL_IN.foreground_cal_done;
        rd_value[BIT_CAL_BUSY] = CAL_IN.offset_cal_busy;
        rd_value[BIT_CLASH]    = cur.clash;
        rd_value[BIT_LOADED]   = fuse_loaded;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    unique case (cur.aw_idx)
      IDX_ALARM_SUMMARY, IDX_ALARM_STATUS, IDX_ALARM_MASK, IDX_LANE_FIFO,
      IDX_CORE0_TRIM, IDX_CORE1_TRIM, IDX_CORE2A_TRIM, IDX_CAL_CTRL, IDX_CAL_STATUS: begin
        wr_hit = 1'b1;
      end
      default: begin
        wr_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_cur = cur;

    // fuse strobe comes from another domain; only the second stage is read
    next_cur.fuse_sync = {cur.fuse_sync[0], FUSE_READY};

    // write address and data are captured independently, in either order
    if (aw_take) begin
      next_cur.aw_held = 1'b1;
      next_cur.aw_idx  = AXI_REQ.awaddr[ADDR_W-1:2];
    end
    if (w_take) begin
      next_cur.w_held = 1'b1;
      next_cur.wdata  = AXI_REQ.wdata;
      next_cur.wstrb  = AXI_REQ.wstrb;
    end
    if (cur.bvalid && AXI_REQ.bready) begin
      next_cur.bvalid = 1'b0;
    end
    if (cur.rvalid && AXI_REQ.rready) begin
      next_cur.rvalid = 1'b0;
    end

    // reads have no side effects except flagging a clash on a trim read in a restricted window
    if (ar_take) begin
      next_cur.rvalid = 1'b1;
      next_cur.rdata  = rd_value;
      next_cur.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end

    // software clears first; hardware sets below win in the same cycle
    if (wr_commit) begin
      next_cur.aw_held = 1'b0;
      next_cur.w_held  = 1'b0;
      next_cur.bvalid  = 1'b1;
      next_cur.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
      if (cur.wstrb[0]) begin
        unique case (cur.aw_idx)
          IDX_ALARM_MASK: begin
            next_cur.mask = cur.wdata[7:0];
          end
          IDX_ALARM_STATUS: begin
            next_cur.status = cur.status & ~cur.wdata[5:0];
            if (cur.wdata[BIT_FIFO]) begin
              next_cur.lane = '0;
            end
          end
          IDX_LANE_FIFO: begin
            next_cur.lane = cur.lane & ~cur.wdata[LANES-1:0];
          end
          IDX_CAL_CTRL: begin
            next_cur.cal_ctrl = cur.wdata[2:0];
          end
          IDX_CAL_STATUS: begin
            if (cur.wdata[BIT_CLASH]) begin
              next_cur.clash = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
      // trims take byte lanes 0 and 1; reserved 15:12 stored as written
      for (int i = 0; i < TRIMS; i++) begin
        if (wr_trim_sel[i]) begin
          next_cur.trim[i] = (cur.trim[i] & ~wr_bytemask) | (cur.wdata[REG_W-1:0] & wr_bytemask);
        end
      end
    end

    // calibration engine results override software in the same cycle
    for (int i = 0; i < TRIMS; i++) begin
      if (CAL_IN.trim_we[i]) begin
        next_cur.trim[i] = {RSVD_TRIM, CAL_IN.trim_value};
      end
      if (fuse_load) begin
        next_cur.trim[i] = {RSVD_TRIM, FUSE_TRIM[i]};
      end
    end

    // hardware sets win over a simultaneous write-one clear
    next_cur.status = next_cur.status | status_set;
    next_cur.lane   = next_cur.lane | FAULT_IN.lane_fifo_fault;

    // misuse is only flagged; the access itself still goes through
    // blocking it would hide the software fault instead of recording it
    if ((wr_commit && wr_is_trim) || (ar_take && rd_is_trim)) begin
      if (restricted) begin
        next_cur.clash = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cur.aw_held  <= 1'b0;
      cur.aw_idx   <= '0;
      cur.w_held   <= 1'b0;
      cur.wdata    <= '0;
      cur.wstrb    <= 4'h0;
      cur.bvalid   <= 1'b0;
      cur.bresp    <= RESP_OKAY;
      cur.rvalid   <= 1'b0;
      cur.rdata    <= '0;
      cur.rresp    <= RESP_OKAY;
      cur.mask     <= MASK_RESET;
      cur.status   <= STATUS_RESET;
      cur.lane     <= LANE_RESET;
      cur.trim     <= {TRIMS{TRIM_RESET}};
      cur.cal_ctrl <= CAL_CTRL_RESET;
      cur.clash    <= 1'b0;
      cur.fuse_sync <= 2'h0;
    end else begin
      cur <= next_cur;
    end
  end

  always_comb begin
    AXI_RSP         = '0;
    AXI_RSP.awready = !cur.aw_held && !cur.bvalid;
    AXI_RSP.wready  = !cur.w_held && !cur.bvalid;
    AXI_RSP.bvalid  = cur.bvalid;
    AXI_RSP.bresp   = cur.bresp;
    AXI_RSP.arready = !cur.rvalid;
    AXI_RSP.rvalid  = cur.rvalid;
    AXI_RSP.rdata   = cur.rdata;
    AXI_RSP.rresp   = cur.rresp;
  end

  generate
    for (genvar g = 0; g < TRIMS; g++) begin : g_trim_out
      assign CORE_TRIM[g] = cur.trim[g][TRIM_W-1:0];
    end
  endgenerate

  assign ALARM_SUMMARY    = summary;
  assign OFFSET_CAL_EN    = offset_cal_enable;
  assign BG_CAL_EN        = background_cal_enable;
  assign BG_OFFSET_CAL_EN = background_cal_enable && background_offset_cal_enable && offset_cal_enable;
  // spare cores still get offset work in the foreground pass
  assign SPARE_FG_OFFSET_CAL_EN = background_cal_enable && offset_cal_enable && !background_offset_cal_enable;
  assign TRIM_ACCESS_OK         = !restricted;

endmodule

// ==== test/amo_regs_assertions.sv ====
`timescale 1ns/1ns
module amo_checker (
  input wire logic                  CLK,
  input wire logic                  RESET_N,
  input wire amo_pkg::amo_axi_req_s AXI_REQ,
  input wire amo_pkg::amo_axi_rsp_s AXI_RSP,
  input wire amo_pkg::amo_cal_s     CAL_IN,
  input wire logic                  OFFSET_CAL_EN,
  input wire logic                  BG_CAL_EN,
  input wire logic                  BG_OFFSET_CAL_EN,
  input wire logic                  SPARE_FG_OFFSET_CAL_EN,
  input wire logic                  TRIM_ACCESS_OK
);
  import amo_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  sequence s_wr_taken;
    AXI_REQ.awvalid && AXI_RSP.awready && AXI_REQ.wvalid && AXI_RSP.wready;
  endsequence
  sequence s_rd_taken;
    AXI_REQ.arvalid && AXI_RSP.arready;
  endsequence
  // commit takes one registered cycle after capture
  a_write_answer: assert property (s_wr_taken |-> ##2 AXI_RSP.bvalid)
    else $error("write response not two cycles after capture");
  a_read_answer: assert property (s_rd_taken |=> AXI_RSP.rvalid)
    else $error("read data not one cycle after capture");
  a_write_refused: assert property (AXI_RSP.bvalid |-> !AXI_RSP.awready && !AXI_RSP.wready)
    else $error("write accepted while response pending");
  a_read_refused: assert property (AXI_RSP.rvalid |-> !AXI_RSP.arready)
    else $error("read accepted while data pending");
  a_busy_blocks: assert property (CAL_IN.offset_cal_busy |-> !TRIM_ACCESS_OK)
    else $error("trim access allowed during offset calibration");
  a_fg_wait: assert property (OFFSET_CAL_EN && !BG_OFFSET_CAL_EN && !CAL_IN.foreground_cal_done |-> !TRIM_ACCESS_OK)
    else $error("trim access allowed before foreground done");
  a_bg_both: assert property (BG_OFFSET_CAL_EN |-> !TRIM_ACCESS_OK)
    else $error("trim access allowed with both background enables");
  a_spare_cores: assert property (SPARE_FG_OFFSET_CAL_EN ==
    (BG_CAL_EN && OFFSET_CAL_EN && !BG_OFFSET_CAL_EN))
    else $error("spare core calibration in wrong mode");
  a_free_access: assert property (!OFFSET_CAL_EN && !BG_CAL_EN && !CAL_IN.offset_cal_busy |-> TRIM_ACCESS_OK)
    else $error("trim access refused outside restricted modes");
endmodule

// ==== test/testbench.sv ====
`timescale 1ns/1ns
module testbench;
  import amo_pkg::*;
  logic         clk;
  logic         reset_n;
  logic         fuse_ready;
  amo_axi_req_s req;
  amo_axi_rsp_s rsp;
  amo_fault_s   fault;
  amo_cal_s     cal;
  amo_trim_t    fuse_trim;
  amo_trim_t    core_trim;
  wire [5:0]    flags;
  logic [31:0]  rd;
  logic [1:0]   resp;
  int           bad_count = 0;
  int           num_checks = 0;

  amo_regs amo_regs_inst (.CLK(clk), .RESET_N(reset_n), .AXI_REQ(req), .AXI_RSP(rsp), .FAULT_IN(fault),
    .CAL_IN(cal), .FUSE_READY(fuse_ready), .FUSE_TRIM(fuse_trim), .CORE_TRIM(core_trim),
    .ALARM_SUMMARY(flags[0]), .OFFSET_CAL_EN(flags[1]), .BG_CAL_EN(flags[2]), .BG_OFFSET_CAL_EN(flags[3]),
    .SPARE_FG_OFFSET_CAL_EN(flags[4]), .TRIM_ACCESS_OK(flags[5]));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // handshakes judged at the falling edge, where ready has settled before the next rising edge
  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic aw_t, w_t, b_t;
    req.awaddr  <= {idx, 2'b00};
    req.wdata   <= d;
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    do begin
      @(negedge clk);
      aw_t = req.awvalid && rsp.awready;
      w_t  = req.wvalid && rsp.wready;
      b_t  = rsp.bvalid;
      resp = rsp.bresp;
      @(posedge clk);
      if (aw_t) req.awvalid <= 1'b0;
      if (w_t) req.wvalid <= 1'b0;
    end while (!b_t);
  endtask

  task automatic rd_reg(input logic [9:0] idx);
    logic ar_t, r_t;
    req.araddr  <= {idx, 2'b00};
    req.arvalid <= 1'b1;
    do begin
      @(negedge clk);
      ar_t = req.arvalid && rsp.arready;
      r_t  = rsp.rvalid;
      rd   = rsp.rdata;
      resp = rsp.rresp;
      @(posedge clk);
      if (ar_t) req.arvalid <= 1'b0;
    end while (!r_t);
  endtask

  task automatic rc(input logic [9:0] idx, input logic [31:0] exp, input string name);
    rd_reg(idx);
    check(name, rd, exp);
  endtask

  task automatic chk_flags(input string name, input logic [5:0] sel, exp);
    @(negedge clk);
    check(name, {26'h0, flags & sel}, {26'h0, exp});
    @(posedge clk);
  endtask

  task automatic chk_trim(input int i, input logic [11:0] exp);
    @(negedge clk);
    check("core trim", {20'h0, core_trim[i]}, {20'h0, exp});
    @(posedge clk);
  endtask

  task automatic fault_pulse(input int b);
    case (b)
      5: fault <= '{lane_fifo_fault: 8'h08, lane_active: 8'h08, default: '0};
      4: fault.pll_unlock <= 1'b1;
      3: fault.link_down <= 1'b1;
      2: fault.realign <= 1'b1;
      default: fault.divider_mismatch <= 1'b1;
    endcase
    @(posedge clk);
    fault <= '0;
    repeat (2) @(posedge clk);
  endtask

  initial begin
    int bits[5];
    logic [5:0] e;
    bits = '{5, 4, 3, 2, 0};
    reset_n = 1'b0;
    fuse_ready = 1'b0;
    req = '{wstrb: 4'hf, bready: 1'b1, rready: 1'b1, default: '0};
    fault = '0;
    cal = '0;
    fuse_trim = {12'h3c3, 12'h2b2, 12'h1a1};
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rc(IDX_ALARM_MASK, 32'h3f, "mask reset");
    rc(IDX_LANE_FIFO, 32'hff, "lane reset");
    rc(IDX_CORE1_TRIM, 32'h0, "trim before fuse");
    chk_flags("summary all masked", 6'h01, 6'h00);
    fuse_ready <= 1'b1;
    // two synchroniser stages sit ahead of the loader
    repeat (6) @(posedge clk);
    fuse_trim <= '0;
    repeat (3) @(posedge clk);
    chk_trim(0, 12'h1a1);
    rc(IDX_CORE2A_TRIM, 32'h3c3, "fuse trim read");
    rc(IDX_CAL_STATUS, 32'h8, "fuse loaded flag");
    wr(IDX_ALARM_STATUS, 32'h3f);
    wr(IDX_ALARM_MASK, 32'h02);
    chk_flags("summary clear", 6'h01, 6'h00);
    for (int i = 0; i < 5; i++) begin
      fault_pulse(bits[i]);
      rc(IDX_ALARM_STATUS, 32'h1 << bits[i], "status set");
      chk_flags("summary unmasked", 6'h01, 6'h01);
      rc(IDX_ALARM_SUMMARY, 32'h1, "summary reg unmasked");
      wr(IDX_ALARM_MASK, 32'h02 | (32'h1 << bits[i]));
      chk_flags("summary masked", 6'h01, 6'h00);
      rc(IDX_ALARM_SUMMARY, 32'h0, "summary reg masked");
      wr(IDX_ALARM_STATUS, 32'h1 << bits[i]);
      wr(IDX_ALARM_MASK, 32'h02);
      chk_flags("summary cleared", 6'h01, 6'h00);
    end
    rc(IDX_LANE_FIFO, 32'h0, "lanes cleared by status");
    fault.lane_fifo_fault <= 8'h81;
    @(posedge clk);
    fault <= '0;
    rc(IDX_LANE_FIFO, 32'h81, "lane set");
    rc(IDX_ALARM_STATUS, 32'h0, "inactive lanes");
    wr(IDX_LANE_FIFO, 32'h00);
    rc(IDX_LANE_FIFO, 32'h81, "lane write zero");
    wr(IDX_LANE_FIFO, 32'h01);
    rc(IDX_LANE_FIFO, 32'h80, "lane write one");
    // a fault still present must win over the clearing write
    fault.lane_fifo_fault <= 8'h40;
    wr(IDX_LANE_FIFO, 32'h40);
    rc(IDX_LANE_FIFO, 32'hc0, "lane persists");
    fault <= '0;
    wr(IDX_ALARM_STATUS, 32'h20);
    rc(IDX_LANE_FIFO, 32'h0, "lanes cleared");
    wr(IDX_CORE1_TRIM, 32'h1234_0abc);
    wr(IDX_CORE2A_TRIM, 32'h0000_0123);
    rc(IDX_CORE1_TRIM, 32'h0abc, "trim one");
    rc(IDX_CORE2A_TRIM, 32'h0123, "trim two");
    chk_trim(1, 12'habc);
    chk_trim(2, 12'h123);
    chk_trim(0, 12'h1a1);
    // calibration engine result replaces one trim only
    cal.trim_value <= 12'h5a5;
    cal.trim_we    <= 3'b100;
    @(posedge clk);
    cal.trim_we    <= 3'b000;
    chk_trim(2, 12'h5a5);
    chk_trim(1, 12'habc);
    rc(IDX_CORE2A_TRIM, 32'h05a5, "engine trim read");
    wr(10'h100, 32'h1);
    check("unmapped write", {30'h0, resp}, {30'h0, RESP_SLVERR});
    rc(10'h100, 32'h0, "unmapped data");
    check("unmapped read", {30'h0, resp}, {30'h0, RESP_SLVERR});
    for (int v = 0; v < 8; v++) begin
      wr(IDX_CAL_CTRL, v);
      e = {!(v[0] && !(v[1] && v[2])) && !(v[1] && v[2]), v[1] && v[0] && !v[2], v[0] && v[1] && v[2],
           v[1], v[0], 1'b0};
      chk_flags("cal outputs", 6'h3e, e);
    end
    cal.foreground_cal_done <= 1'b1;
    wr(IDX_CAL_CTRL, 32'h1);
    chk_flags("access after done", 6'h20, 6'h20);
    cal.offset_cal_busy <= 1'b1;
    wr(IDX_CAL_CTRL, 32'h0);
    chk_flags("access while busy", 6'h20, 6'h00);
    give_verdict;
  end

  // whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    give_verdict;
  end
endmodule

bind amo_regs amo_checker amo_checker_inst (.CLK(CLK), .RESET_N(RESET_N), .AXI_REQ(AXI_REQ), .AXI_RSP(AXI_RSP),
  .CAL_IN(CAL_IN), .OFFSET_CAL_EN(OFFSET_CAL_EN), .BG_CAL_EN(BG_CAL_EN), .BG_OFFSET_CAL_EN(BG_OFFSET_CAL_EN),
  .SPARE_FG_OFFSET_CAL_EN(SPARE_FG_OFFSET_CAL_EN), .TRIM_ACCESS_OK(TRIM_ACCESS_OK));
